// ---- rtl/ctsf_defines.vh ----
// Constants for the clock trim calibrator status-flag block
`ifndef CTSF_DEFINES_VH
`define CTSF_DEFINES_VH
`define CTSF_CNT_W 16
`define CTSF_LIM_W 8
`define CTSF_TRIM_W 7
`define CTSF_OK_MULT 24'h000003
`define CTSF_WARN_MULT 24'h000080
`define CTSF_TRIM_STEP 7'h02
`define CTSF_TRIM_MAX 7'h7F
`define CTSF_TRIM_MIN 7'h00
`define CTSF_TRIM_RST 7'h40
`define CTSF_STAT_OK_BIT 0
`define CTSF_STAT_WARN_BIT 1
`endif

// ---- rtl/ctsf_sync.v ----
// Two-flop synchroniser for the reference pulse
`timescale 1ns/1ns
`default_nettype none
module ctsf_sync (
   // Clock and reset
   input wire clk_in,
   input wire srst_in,
   // Data
   input wire d_in,
   output wire q_out
);
   reg meta;
   reg stable;
   always @(posedge clk_in) begin
      if (srst_in) begin
         meta <= 1'b0;
         stable <= 1'b0;
      end else begin
         meta <= d_in;
         stable <= meta;
      end
   end
   assign q_out = stable;
endmodule
`default_nettype wire

// ---- rtl/ctsf_top.v ----
// Status flags and trim stepping of the clock trim calibrator
// Functional notes
// - Sync reference pulse with counter below 3x limit sets success flag.
// - Success interrupt raised only while success interrupt enable is one.
// - Writing one to success clear bit clears success flag.
// - Success flag is status bit 0, read-only, resets to zero.
// - Success flag reads 0 when unsuccessful, 1 when successful.
// - Warning flag reads 1 after a warning, 0 otherwise.
// - Success leaves trim code unchanged; frequency treated as normal.
// - Pulse with counter in [3x, 128x) limit sets warning flag.
// - On warning, trim code steps by two toward correct frequency.
`timescale 1ns/1ns
`default_nettype none
`include "ctsf_defines.vh"
module ctsf_top (
   // Clock and reset
   input wire REF_CLK_IN,
   input wire SRST_IN,
   // Reference pulse pin
   input wire REF_PULSE_IN,
   // Calibration counter state from the counter logic (same clock)
   input wire [`CTSF_CNT_W-1:0] CALIB_COUNT_IN,
   input wire [`CTSF_LIM_W-1:0] COUNT_LIMIT_IN,
   input wire COUNT_DOWN_IN,
   // Control bits
   input wire CALIB_OK_IRQ_ENABLE_IN,
   input wire CALIB_WARN_IRQ_ENABLE_IN,
   input wire CALIB_OK_CLEAR_IN,
   input wire CALIB_WARN_CLEAR_IN,
   // Status
   output wire [1:0] STATUS_OUT,
   output wire [`CTSF_TRIM_W-1:0] TRIM_CODE_OUT,
   output wire CALIB_OK_IRQ_OUT,
   output wire CALIB_WARN_IRQ_OUT,
   output wire REF_PULSE_SEEN_OUT
);
   wire ref_sync;
   reg ref_sync_d;
   reg calib_ok_flag;
   reg calib_warn_flag;
   reg [`CTSF_TRIM_W-1:0] trim_code;
   reg [`CTSF_TRIM_W-1:0] next_trim_code;
   reg pulse_seen;
   wire ref_edge;
   wire [`CTSF_CNT_W+7:0] count_ext;
   wire [`CTSF_CNT_W+7:0] ok_bound;
   wire [`CTSF_CNT_W+7:0] warn_bound;
   wire in_ok;
   wire in_warn;

   ctsf_sync u_sync (
      .clk_in(REF_CLK_IN),
      .srst_in(SRST_IN),
      .d_in(REF_PULSE_IN),
      .q_out(ref_sync)
   );

   assign ref_edge = ref_sync & ~ref_sync_d;
   assign count_ext = {8'h00, CALIB_COUNT_IN};
   assign ok_bound = {{(`CTSF_CNT_W){1'b0}}, COUNT_LIMIT_IN} * `CTSF_OK_MULT;
   assign warn_bound = {{(`CTSF_CNT_W){1'b0}}, COUNT_LIMIT_IN} * `CTSF_WARN_MULT;
   assign in_ok = count_ext < ok_bound;
   assign in_warn = (count_ext >= ok_bound) && (count_ext < warn_bound);

   // With COUNT_DOWN_IN high a warning steps the trim field up, else down; saturate
   always @* begin
      next_trim_code = trim_code;
      if (ref_edge && in_warn) begin
         if (COUNT_DOWN_IN) begin
            if (trim_code <= `CTSF_TRIM_MAX - `CTSF_TRIM_STEP)
               next_trim_code = trim_code + `CTSF_TRIM_STEP;
            else
               next_trim_code = `CTSF_TRIM_MAX;
         end else begin
            if (trim_code >= `CTSF_TRIM_MIN + `CTSF_TRIM_STEP)
               next_trim_code = trim_code - `CTSF_TRIM_STEP;
            else
               next_trim_code = `CTSF_TRIM_MIN;
         end
      end
   end

   always @(posedge REF_CLK_IN) begin
      if (SRST_IN) begin
         ref_sync_d <= 1'b0;
         calib_ok_flag <= 1'b0;
         calib_warn_flag <= 1'b0;
         trim_code <= `CTSF_TRIM_RST;
         pulse_seen <= 1'b0;
      end else begin
         ref_sync_d <= ref_sync;
         pulse_seen <= ref_edge;
         // Set wins over a clear in the same cycle; flag holds otherwise
         if (ref_edge && in_ok)
            calib_ok_flag <= 1'b1;
         else if (CALIB_OK_CLEAR_IN)
            calib_ok_flag <= 1'b0;
         if (ref_edge && in_warn)
            calib_warn_flag <= 1'b1;
         else if (CALIB_WARN_CLEAR_IN)
            calib_warn_flag <= 1'b0;
         trim_code <= next_trim_code;
      end
   end

   assign STATUS_OUT[`CTSF_STAT_OK_BIT] = calib_ok_flag;
   assign STATUS_OUT[`CTSF_STAT_WARN_BIT] = calib_warn_flag;
   assign TRIM_CODE_OUT = trim_code;
   assign CALIB_OK_IRQ_OUT = calib_ok_flag & CALIB_OK_IRQ_ENABLE_IN;
   assign CALIB_WARN_IRQ_OUT = calib_warn_flag & CALIB_WARN_IRQ_ENABLE_IN;
   assign REF_PULSE_SEEN_OUT = pulse_seen;
endmodule
`default_nettype wire

// ---- bench/ctsf_monitor.sv ----
// Flag checker
`timescale 1ns/1ns
`default_nettype none
module ctsf_mon (
   input wire REF_CLK_IN, SRST_IN, COUNT_DOWN_IN, CALIB_OK_CLEAR_IN, CALIB_OK_IRQ_OUT,
   input wire CALIB_OK_IRQ_ENABLE_IN, REF_PULSE_SEEN_OUT, input wire [1:0] STATUS_OUT,
   input wire [15:0] CALIB_COUNT_IN, input wire [7:0] COUNT_LIMIT_IN, input wire [6:0] TRIM_CODE_OUT
);
   reg k, w;
   wire s = REF_PULSE_SEEN_OUT, o = STATUS_OUT[0];
   wire [6:0] t = TRIM_CODE_OUT;
   wire [31:0] c = CALIB_COUNT_IN, l = COUNT_LIMIT_IN;
   always @(posedge REF_CLK_IN) {k, w} <= {c < 3 * l, c >= 3 * l && c < 128 * l};
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (SRST_IN);
   a_ok_set: assert property (s && k |-> o) else $error("ok");
   a_ok_cause: assert property ($rose(o) |-> s && k) else $error("cause");
   a_ok_irq: assert property (CALIB_OK_IRQ_OUT == (o && CALIB_OK_IRQ_ENABLE_IN))
      else $error("irq");
   a_ok_clear: assert property (CALIB_OK_CLEAR_IN |=> !o || s) else $error("clear");
   a_ok_hold: assert property (o && !CALIB_OK_CLEAR_IN |=> o) else $error("hold");
   a_warn_set: assert property (s && w |-> STATUS_OUT[1]) else $error("warn");
   a_trim_keep: assert property (s && !w |-> $stable(t)) else $error("trim");
   a_trim_step: assert property (s && w && $past(t) inside {[2:125]}
      |-> t == $past(t) + ($past(COUNT_DOWN_IN) ? 2 : -2)) else $error("step");
   cover property (s && k);
   cover property (s && w);
   cover property (CALIB_OK_CLEAR_IN && o);
endmodule
bind ctsf_top ctsf_mon ctsf_mon_inst (.*);
`default_nettype wire

// ---- bench/tb_ctsf_top.sv ----
// Random bench for the flag block
`timescale 1ns/1ns
`default_nettype none
module tb_ctsf_top;
   logic REF_CLK_IN = 0, SRST_IN = 1, REF_PULSE_IN = 0, COUNT_DOWN_IN = 0, CALIB_OK_CLEAR_IN = 0;
   logic CALIB_OK_IRQ_ENABLE_IN = 0, CALIB_WARN_IRQ_ENABLE_IN = 0, CALIB_WARN_CLEAR_IN = 0;
   logic CALIB_OK_IRQ_OUT, CALIB_WARN_IRQ_OUT, REF_PULSE_SEEN_OUT;
   logic [15:0] CALIB_COUNT_IN = 0;
   logic [7:0] COUNT_LIMIT_IN = 0;
   logic [6:0] TRIM_CODE_OUT;
   logic [1:0] STATUS_OUT;
   int failures = 0, n_checks = 0, cyc = 0, ok = 0, wn = 0, tr = 64, l, r;
   bit [31:0] x = 32'hF486;
   ctsf_top ctsf_top_inst (.*);
   initial forever #4 REF_CLK_IN = ~REF_CLK_IN;
   function automatic int rnd();
      x ^= x << 13; x ^= x >> 17; x ^= x << 5;
      return x & 32'hFFFF;
   endfunction
   task automatic chk(string n, logic [9:0] v, e);
      n_checks++;
      if (v !== e) failures++;
      if (v !== e) $display("[ERR] %s exp %0h seen %0h", n, e, v);
   endtask
   task automatic finish_test();
      $display("failures %0d checks %0d", failures, n_checks);
      if (failures == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(negedge REF_CLK_IN) if (++cyc > 999) begin failures++; finish_test(); end
   initial begin
      repeat (12) @(negedge REF_CLK_IN);
      SRST_IN = 0;
      chk("rst", STATUS_OUT, 0);
      repeat (60) begin
         l = rnd() % 200 + 1;
         r = rnd() % 3;
         COUNT_LIMIT_IN = 8'(l);
         CALIB_COUNT_IN = 16'(r ? (r > 1 ? 128 * l : 3 * l + rnd() % (125 * l)) : rnd() % (3 * l));
         COUNT_DOWN_IN = tr < 3 || tr < 125 && x[0];
         CALIB_OK_IRQ_ENABLE_IN = x[1];
         CALIB_WARN_IRQ_ENABLE_IN = x[3];
         REF_PULSE_IN = 1;
         @(negedge REF_CLK_IN) REF_PULSE_IN = 0;
         repeat (2) @(negedge REF_CLK_IN);
         chk("seen", REF_PULSE_SEEN_OUT, 10'(1));
         @(negedge REF_CLK_IN);
         chk("seen_end", REF_PULSE_SEEN_OUT, 10'(0));
         ok |= r == 0;
         wn |= r == 1;
         tr += r == 1 ? (COUNT_DOWN_IN ? 2 : -2) : 0;
         chk("out", {TRIM_CODE_OUT, STATUS_OUT, CALIB_OK_IRQ_OUT}, 10'(tr * 8 + wn * 4 + ok * 2 + (ok & CALIB_OK_IRQ_ENABLE_IN)));
         chk("wirq", CALIB_WARN_IRQ_OUT, 10'(wn & CALIB_WARN_IRQ_ENABLE_IN));
         CALIB_OK_CLEAR_IN = x[2];
         CALIB_WARN_CLEAR_IN = x[4];
         @(negedge REF_CLK_IN) ok &= !CALIB_OK_CLEAR_IN;
         wn &= !CALIB_WARN_CLEAR_IN;
         CALIB_OK_CLEAR_IN = 0;
         CALIB_WARN_CLEAR_IN = 0;
         chk("clr", STATUS_OUT[0], 10'(ok));
         chk("wclr", STATUS_OUT[1], 10'(wn));
      end
      finish_test();
   end
endmodule
`default_nettype wire
